// File: rtl/cfg_lock_pkg.sv
// Constants and carrier types for the configuration protection and lock block
`default_nettype none
package cfg_lock_pkg;
   // ***************
   // Register map
   // ***************
   localparam int unsigned    ADDR_W     = 8;
   localparam logic [7:0]     CTRL_OFS   = 8'h00;
   localparam logic [7:0]     WORD0_OFS  = 8'h04;
   localparam logic [7:0]     STAT_OFS   = 8'h08;
   localparam logic [7:0]     GATE_OFS   = 8'h10;
   localparam int unsigned    GATE_CNT   = 6;
   localparam logic [1:0]     RESP_OKAY  = 2'h0;
   localparam logic [1:0]     RESP_SLVERR = 2'h2;
   // ***************
   // Field positions
   // ***************
   localparam int unsigned    LOCK_BIT   = 12;
   localparam int unsigned    SCAN_BIT   = 3;
   localparam int unsigned    ONE_WAY_BIT = 28;
   localparam int unsigned    PROTECT_N_BIT = 28;
   localparam int unsigned    BOOT_WE_BIT   = 24;
   localparam int unsigned    FLASH_PROT_HI = 15;
   localparam int unsigned    FLASH_PROT_LO = 10;
   localparam int unsigned    ICE_HI     = 4;
   localparam int unsigned    ICE_LO     = 3;
   localparam int unsigned    JTAG_BIT   = 2;
   localparam int unsigned    DBG_HI     = 1;
   localparam int unsigned    DBG_LO     = 0;
   localparam int unsigned    STAT_LOADED_BIT = 0;
   localparam int unsigned    STAT_ONE_WAY_BIT = 1;
   localparam int unsigned    STAT_FROZEN_BIT = 2;
   // ***************
   // Values
   // ***************
   localparam logic [5:0]     FLASH_PROT_OFF = 6'h3f;
   localparam logic [1:0]     DBG_FORCED = 2'h3;
   localparam int unsigned    PAGE_SHIFT = 10;
   localparam logic [31:0]    CFG0_RST   = 32'h0000_0000;
   localparam logic [31:0]    GATE_RST   = 32'h0000_0000;

   typedef enum {LOAD_WAIT, LOAD_DONE} load_state_t;

   typedef struct packed {
      logic [15:0] flash_protect_limit;
      logic        prog_access_block;
      logic        boot_flash_write_enable;
      logic [3:0]  pin_pair_sel;
      logic        debugger_enable;
      logic [1:0]  debug_field_eff;
   } protect_ctrl_t;
endpackage
`default_nettype wire

// File: rtl/config_protect_lock.sv
// Configuration protection, module-disable write lock and config word decode
// Functional notes
// - Locked module-disable writes succeed but change nothing
// - Write lock lives in control register bit 12
// - Lock changes need completed unlock sequence first
// - One-way option stops lock being cleared
// - One-way locked: unlock void, pin-select writes refused
// - Only device reset clears one-way lock
// - Word-zero bit 28 low blocks external programmer
// - Word-zero bit 24 low blocks boot flash writes
// - Six-bit field sets protected flash boundary
// - Two-bit field picks debug programming pin pair
// - Word-zero bit 2 presets scan port enable
// - Upper debug bit zero enables; protect forces 11
// - Set gate bit stops peripheral clocks and access
`default_nettype none
module config_protect_lock
   import cfg_lock_pkg::*;
#(
   parameter int unsigned GATES = cfg_lock_pkg::GATE_CNT
) (
   input  wire logic                          CLK_SYS_I,
   input  wire logic                          SYS_RST_I,
   input  wire logic [31:0]                   CFG_WORD_ZERO_I,
   input  wire logic [31:0]                   CFG_WORD_THREE_I,
   input  wire logic                          SYS_UNLOCKED_I,
   input  wire logic [cfg_lock_pkg::ADDR_W-1:0] AWADDR_I,
   input  wire logic                          AWVALID_I,
   output logic                               AWREADY_O,
   input  wire logic [31:0]                   WDATA_I,
   input  wire logic [3:0]                    WSTRB_I,
   input  wire logic                          WVALID_I,
   output logic                               WREADY_O,
   output logic [1:0]                         BRESP_O,
   output logic                               BVALID_O,
   input  wire logic                          BREADY_I,
   input  wire logic [cfg_lock_pkg::ADDR_W-1:0] ARADDR_I,
   input  wire logic                          ARVALID_I,
   output logic                               ARREADY_O,
   output logic [31:0]                        RDATA_O,
   output logic [1:0]                         RRESP_O,
   output logic                               RVALID_O,
   input  wire logic                          RREADY_I,
   output logic [GATES*32-1:0]                MODULE_CLOCK_GATE_O,
   output logic                               PIN_SELECT_WRITE_BLOCK_O,
   output logic                               SCAN_PORT_ENABLE_O,
   output cfg_lock_pkg::protect_ctrl_t        PROTECT_CTRL_O
);
   import cfg_lock_pkg::*;

   // ***************
   // Configuration load
   // ***************
   load_state_t   load_st_r, load_st_nxt;
   logic [31:0]   word0_r, word0_nxt;
   logic          one_way_r, one_way_nxt;
   protect_ctrl_t prot_r, prot_nxt;
   logic          loaded;
   logic [FLASH_PROT_HI-FLASH_PROT_LO:0] pages_inv;

   assign loaded    = (load_st_r == LOAD_DONE);
   assign pages_inv = ~word0_r[FLASH_PROT_HI:FLASH_PROT_LO];

   // Words are taken on the first edge after reset release, never under reset
   always_comb begin
      load_st_nxt = load_st_r;
      word0_nxt   = word0_r;
      one_way_nxt = one_way_r;
      case (load_st_r)
         LOAD_WAIT: begin
            word0_nxt   = CFG_WORD_ZERO_I;
            one_way_nxt = CFG_WORD_THREE_I[ONE_WAY_BIT];
            load_st_nxt = LOAD_DONE;
         end
         default: begin
            load_st_nxt = LOAD_DONE;
         end
      endcase
   end

   always_comb begin
      prot_nxt = '0;
      prot_nxt.prog_access_block       = ~word0_r[PROTECT_N_BIT];
      prot_nxt.boot_flash_write_enable = word0_r[BOOT_WE_BIT];
      // All ones leaves nothing protected; each step down adds one page
      if (word0_r[FLASH_PROT_HI:FLASH_PROT_LO] != FLASH_PROT_OFF) begin
         prot_nxt.flash_protect_limit = 16'(pages_inv) << PAGE_SHIFT;
      end
      prot_nxt.pin_pair_sel = 4'h1 << (2'h3 - word0_r[ICE_HI:ICE_LO]);
      if (~word0_r[PROTECT_N_BIT]) begin
         prot_nxt.debug_field_eff = DBG_FORCED;
      end else begin
         prot_nxt.debug_field_eff = word0_r[DBG_HI:DBG_LO];
      end
      prot_nxt.debugger_enable = ~prot_nxt.debug_field_eff[1];
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         load_st_r <= LOAD_WAIT;
         word0_r   <= CFG0_RST;
         one_way_r <= 1'b0;
         prot_r    <= '0;
      end else begin
         load_st_r <= load_st_nxt;
         word0_r   <= word0_nxt;
         one_way_r <= one_way_nxt;
         prot_r    <= prot_nxt;
      end
   end

   // ***************
   // Register bus
   // ***************
   logic              aw_hold_r, aw_hold_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic              w_hold_r, w_hold_nxt;
   logic [31:0]       w_data_r, w_data_nxt;
   logic [3:0]        w_strb_r, w_strb_nxt;
   logic              bvalid_r, bvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [1:0]        rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              do_write;
   logic [31:0]       strb_mask;

   assign AWREADY_O = ~aw_hold_r & ~bvalid_r;
   assign WREADY_O  = ~w_hold_r & ~bvalid_r;
   assign ARREADY_O = ~rvalid_r;
   assign BVALID_O  = bvalid_r;
   assign BRESP_O   = bresp_r;
   assign RVALID_O  = rvalid_r;
   assign RRESP_O   = rresp_r;
   assign RDATA_O   = rdata_r;
   assign do_write  = aw_hold_r & w_hold_r;
   assign strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

   // ***************
   // Lock and gate registers
   // ***************
   logic                 lock_r, lock_nxt;
   logic                 scan_r, scan_nxt;
   logic [GATES*32-1:0]  gate_r, gate_nxt;
   logic                 frozen;
   logic                 unlock_ok;
   logic                 ctrl_hit, gate_hit;
   logic [ADDR_W-1:0]    gate_idx;

   // A frozen lock voids the unlock sequence entirely
   assign frozen    = one_way_r & lock_r;
   assign unlock_ok = SYS_UNLOCKED_I & ~frozen;
   assign ctrl_hit  = (aw_addr_r == CTRL_OFS);
   assign gate_idx  = ADDR_W'((aw_addr_r - GATE_OFS) >> 2);
   assign gate_hit  = (aw_addr_r >= GATE_OFS) &&
                      (aw_addr_r < ADDR_W'(GATE_OFS + 4 * GATES)) &&
                      (aw_addr_r[1:0] == 2'h0);

   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt  = w_hold_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      lock_nxt    = lock_r;
      scan_nxt    = scan_r;
      gate_nxt    = gate_r;
      if (~loaded) begin
         scan_nxt = CFG_WORD_ZERO_I[JTAG_BIT];
      end
      if (AWVALID_I && AWREADY_O) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = WDATA_I;
         w_strb_nxt = WSTRB_I;
      end
      if (bvalid_r && BREADY_I) begin
         bvalid_nxt = 1'b0;
      end
      if (do_write) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = RESP_OKAY;
         if (ctrl_hit) begin
            if (unlock_ok && w_strb_r[LOCK_BIT / 8]) begin
               lock_nxt = w_data_r[LOCK_BIT];
            end
            if (unlock_ok && w_strb_r[SCAN_BIT / 8]) begin
               scan_nxt = w_data_r[SCAN_BIT];
            end
         end else if (gate_hit) begin
            // Locked writes still answer OKAY but leave the word alone
            if (~lock_r) begin
               gate_nxt[gate_idx * 32 +: 32] = (gate_r[gate_idx * 32 +: 32] & ~strb_mask) |
                                               (w_data_r & strb_mask);
            end
         end else if (aw_addr_r == WORD0_OFS || aw_addr_r == STAT_OFS) begin
            bresp_nxt = RESP_OKAY;
         end else begin
            bresp_nxt = RESP_SLVERR;
         end
      end
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      if (rvalid_r && RREADY_I) begin
         rvalid_nxt = 1'b0;
      end
      if (ARVALID_I && ARREADY_O) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         rdata_nxt  = '0;
         if (ARADDR_I == CTRL_OFS) begin
            rdata_nxt[LOCK_BIT] = lock_r;
            rdata_nxt[SCAN_BIT] = scan_r;
         end else if (ARADDR_I == WORD0_OFS) begin
            rdata_nxt = word0_r;
         end else if (ARADDR_I == STAT_OFS) begin
            rdata_nxt[STAT_LOADED_BIT]  = loaded;
            rdata_nxt[STAT_ONE_WAY_BIT] = one_way_r;
            rdata_nxt[STAT_FROZEN_BIT]  = frozen;
         end else if (ARADDR_I >= GATE_OFS && ARADDR_I < ADDR_W'(GATE_OFS + 4 * GATES) &&
                      ARADDR_I[1:0] == 2'h0) begin
            rdata_nxt = gate_r[ADDR_W'((ARADDR_I - GATE_OFS) >> 2) * 32 +: 32];
         end else begin
            rresp_nxt = RESP_SLVERR;
         end
      end
   end

   // Lock has no path back to zero once frozen except this reset branch
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_hold_r  <= 1'b0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
         lock_r    <= 1'b0;
         scan_r    <= 1'b0;
         gate_r    <= {GATES{GATE_RST}};
      end else begin
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r  <= w_hold_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         lock_r    <= lock_nxt;
         scan_r    <= scan_nxt;
         gate_r    <= gate_nxt;
      end
   end

   assign MODULE_CLOCK_GATE_O      = gate_r;
   assign PIN_SELECT_WRITE_BLOCK_O = frozen;
   assign SCAN_PORT_ENABLE_O       = scan_r;
   assign PROTECT_CTRL_O           = prot_r;

   // ***************
   // Assertions
   // ***************
   property p_locked_gate_hold;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (do_write && gate_hit && lock_r) |=> $stable(gate_r);
   endproperty
   a_locked_gate_hold: assert property (p_locked_gate_hold)
      else $error("gate changed while locked");

   property p_lock_write;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (do_write && ctrl_hit && unlock_ok && w_strb_r[LOCK_BIT / 8]) |=>
         (lock_r == $past(w_data_r[LOCK_BIT]));
   endproperty
   a_lock_write: assert property (p_lock_write)
      else $error("lock bit not written");

   property p_no_unlock_no_change;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (!SYS_UNLOCKED_I) |=> $stable(lock_r);
   endproperty
   a_no_unlock_no_change: assert property (p_no_unlock_no_change)
      else $error("lock moved without unlock");

   property p_one_way_sticky;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (one_way_r && lock_r) |=> lock_r;
   endproperty
   a_one_way_sticky: assert property (p_one_way_sticky)
      else $error("one-way lock cleared");

   property p_pin_sel_block;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      PIN_SELECT_WRITE_BLOCK_O == (one_way_r && lock_r);
   endproperty
   a_pin_sel_block: assert property (p_pin_sel_block)
      else $error("pin select block wrong");

   property p_prog_block;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      loaded |=> (PROTECT_CTRL_O.prog_access_block == !$past(word0_r[PROTECT_N_BIT]));
   endproperty
   a_prog_block: assert property (p_prog_block)
      else $error("code protect decode wrong");

   property p_dbg_forced;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (loaded && !word0_r[PROTECT_N_BIT]) |=>
         (!PROTECT_CTRL_O.debugger_enable && PROTECT_CTRL_O.debug_field_eff == DBG_FORCED);
   endproperty
   a_dbg_forced: assert property (p_dbg_forced)
      else $error("debugger not forced off");

   property p_word0_held;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      loaded |=> $stable(word0_r) && $stable(one_way_r);
   endproperty
   a_word0_held: assert property (p_word0_held)
      else $error("config word changed after load");

   property p_write_resp;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      do_write |=> BVALID_O;
   endproperty
   a_write_resp: assert property (p_write_resp)
      else $error("no write response");

   // A response must stand until the master takes it
   property p_resp_stands;
      @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (bvalid_r && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O));
   endproperty
   a_resp_stands: assert property (p_resp_stands)
      else $error("write response dropped early");

   c_lock_set: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) $rose(lock_r));
   c_frozen:   cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) $rose(frozen));
   c_gate_wr:  cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
                               do_write && gate_hit && !lock_r);
endmodule
`default_nettype wire

// File: bench/cfg_source_model.sv
// Partner model: configuration word store and unlock sequencer beside the block
`default_nettype none
module cfg_source_model (
   input  wire logic        code_protect_n_i,
   input  wire logic        boot_flash_write_enable_i,
   input  wire logic [5:0]  program_flash_protect_field_i,
   input  wire logic [1:0]  debug_channel_select_i,
   input  wire logic        scan_port_enable_i,
   input  wire logic [1:0]  debug_field_i,
   input  wire logic        lock_one_way_option_i,
   input  wire logic        unlock_i,
   output logic [31:0]      word_zero_o,
   output logic [31:0]      word_three_o,
   output logic             unlocked_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Reserved positions are programmed to their fixed values
   assign word_zero_o = {1'b0, 2'b11, code_protect_n_i, 3'b111, boot_flash_write_enable_i,
                         8'hff, program_flash_protect_field_i, 5'h1f,
                         debug_channel_select_i, scan_port_enable_i,
                         debug_field_i};
   // Only the one-way option matters, the other bits are arbitrary
   assign word_three_o = {3'h7, lock_one_way_option_i, 28'hfff_ffff};
   // Level that stands for a completed unlock sequence
   assign unlocked_o = unlock_i;
endmodule
`default_nettype wire

// File: bench/config_protect_lock_test.sv
// Self-checking bench for the configuration protection and lock block
`default_nettype none
module config_protect_lock_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_lock_pkg::*;
   logic          clk, rst, prot_n, boot_we, scan, one_way, unl, awv, wv, bready, arv, rready;
   logic          lock_m, scan_m;
   logic [5:0]    flash_field;
   logic [1:0]    chan_sel, dbg, bresp, rresp;
   logic [7:0]    awaddr, araddr;
   logic [3:0]    strb;
   logic [31:0]   wdata, rdata, w0, w3;
   logic          awready, wready, bvalid, arready, rvalid, pin_blk, scan_en, unlocked;
   logic [191:0]  gate;
   protect_ctrl_t pc;
   logic [31:0]   gate_m [6];
   int            error_cnt, check_count;

   cfg_source_model u_cfg_source_model (.code_protect_n_i(prot_n),
      .boot_flash_write_enable_i(boot_we), .program_flash_protect_field_i(flash_field),
      .debug_channel_select_i(chan_sel), .scan_port_enable_i(scan), .debug_field_i(dbg),
      .lock_one_way_option_i(one_way), .unlock_i(unl), .word_zero_o(w0),
      .word_three_o(w3), .unlocked_o(unlocked));
   config_protect_lock #(.GATES(GATE_CNT)) u_config_protect_lock (.CLK_SYS_I(clk),
      .SYS_RST_I(rst), .CFG_WORD_ZERO_I(w0), .CFG_WORD_THREE_I(w3), .SYS_UNLOCKED_I(unlocked),
      .AWADDR_I(awaddr), .AWVALID_I(awv), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(strb), .WVALID_I(wv), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
      .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .MODULE_CLOCK_GATE_O(gate), .PIN_SELECT_WRITE_BLOCK_O(pin_blk),
      .SCAN_PORT_ENABLE_O(scan_en), .PROTECT_CTRL_O(pc));

   // ***************
   // Reference model
   // ***************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   function automatic int gidx(input logic [7:0] a);
      if (a >= GATE_OFS && a < GATE_OFS + 8'(4 * GATE_CNT) && a[1:0] == 2'b00) begin
         return int'((a - GATE_OFS) >> 2);
      end
      return -1;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == CTRL_OFS || a == WORD0_OFS || a == STAT_OFS || gidx(a) >= 0;
   endfunction

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      if (a == CTRL_OFS) return {19'h0, lock_m, 8'h0, scan_m, 3'h0};
      if (a == WORD0_OFS) return w0;
      if (a == STAT_OFS) return {29'h0, one_way & lock_m, one_way, 1'b1};
      if (gidx(a) >= 0) return gate_m[gidx(a)];
      return 32'h0;
   endfunction

   // Decoded controls, worked out from the fields the bench chose
   function automatic logic [31:0] exp_pc;
      logic [5:0] np;
      logic [1:0] eff;
      np = ~flash_field;
      eff = prot_n ? dbg : 2'b11;
      return {7'h0, (flash_field == 6'h3f) ? 16'h0 : {np, 10'h0}, ~prot_n, boot_we,
              4'(1 << (3 - chan_sel)), ~eff[1], eff};
   endfunction

   task automatic check_outs;
      for (int k = 0; k < 6; k++) begin
         check("gate", gate[k*32+:32], gate_m[k]);
      end
      check("scan", 32'(scan_en), 32'(scan_m));
      check("pin_block", 32'(pin_blk), 32'(one_way & lock_m));
   endtask

   // ***************
   // Bus master
   // ***************
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arv <= 1'b1;
      do @(posedge clk); while (!arready);
      arv <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      check("rdata", rdata, exp_rd(a));
      check("rresp", 32'(rresp), 32'(mapped(a) ? RESP_OKAY : RESP_SLVERR));
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic        ad, wd;
      logic [31:0] m;
      ad = 1'b0;
      wd = 1'b0;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      awaddr <= a;
      wdata <= d;
      strb <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (!ad && awready) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wv <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
      check("bresp", 32'(bresp), 32'(mapped(a) ? RESP_OKAY : RESP_SLVERR));
      // Each byte lane of the control word moves only with its strobe
      if (a == CTRL_OFS && unl && !(one_way && lock_m)) begin
         if (s[LOCK_BIT / 8]) begin
            lock_m = d[LOCK_BIT];
         end
         if (s[SCAN_BIT / 8]) begin
            scan_m = d[SCAN_BIT];
         end
      end
      if (gidx(a) >= 0 && !lock_m) begin
         gate_m[gidx(a)] = (gate_m[gidx(a)] & ~m) | (d & m);
      end
      check_outs();
      rd(a);
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      lock_m = 1'b0;
      scan_m = scan;
      for (int k = 0; k < 6; k++) gate_m[k] = 32'h0;
      check("decode", {7'h0, pc}, exp_pc());
      check_outs();
      rd(WORD0_OFS);
      rd(STAT_OFS);
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Generous bound: the whole sequence needs about six hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      {rst, prot_n, boot_we, scan, one_way, unl, awv, wv, bready, arv, rready} = 11'h400;
      {flash_field, chan_sel, dbg, awaddr, araddr, wdata, strb} = '0;
      error_cnt = 0;
      check_count = 0;
      void'($urandom(32'he35b));
      for (int i = 0; i < 8; i++) begin
         {prot_n, boot_we, scan, dbg} <= 5'($urandom);
         flash_field <= (i == 0) ? 6'h3f : (i == 1) ? 6'h1f : 6'($urandom);
         chan_sel <= 2'(i);
         one_way <= i[0];
         unl <= 1'b0;
         do_reset();
         wr(GATE_OFS + 8'(4 * (i % 6)), $urandom, 4'($urandom));
         wr(CTRL_OFS, 32'h0000_1008, 4'hf);
         wr(WORD0_OFS, 32'h0, 4'hf);
         unl <= 1'b1;
         @(posedge clk);
         wr(CTRL_OFS, 32'h0000_1008, 4'hf);
         wr(GATE_OFS + 8'h14, $urandom, 4'hf);
         wr(CTRL_OFS, 32'h0, 4'hd);
         wr(CTRL_OFS, 32'h0, 4'hf);
         wr(GATE_OFS + 8'h04, $urandom, 4'($urandom));
         wr(8'h40, $urandom, 4'hf);
         rd(8'h30);
      end
      do_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
